// ---- rtl/bwc_pkg.sv ----
package bwc_pkg;

    // ==========================================================
    // Register offsets (seven-bit address field of the frame)
    // ==========================================================
    localparam logic [6:0] BWC_ADDR_BUS_MODE = 7'h04;
    localparam logic [6:0] BWC_ADDR_INT_WAKE = 7'h06;
    localparam logic [6:0] BWC_ADDR_EXT_WAKE = 7'h07;
    localparam logic [6:0] BWC_ADDR_PULL     = 7'h08;

    // ==========================================================
    // Reset values and writable-bit masks
    // ==========================================================
    localparam logic [7:0] BWC_RST_BUS_MODE  = 8'h00;
    localparam logic [7:0] BWC_RST_BUS_DEV   = 8'h03;
    localparam logic [7:0] BWC_RST_INT_WAKE  = 8'h00;
    localparam logic [7:0] BWC_RST_EXT_WAKE  = 8'h01;
    localparam logic [7:0] BWC_RST_PULL      = 8'h00;
    localparam logic [7:0] BWC_MSK_BUS_MODE  = 8'h07;
    localparam logic [7:0] BWC_MSK_INT_WAKE  = 8'h44;
    localparam logic [7:0] BWC_MSK_EXT_WAKE  = 8'ha1;
    localparam logic [7:0] BWC_MSK_PULL      = 8'hc3;
    localparam logic [7:0] BWC_UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BWC_BIT_SWK      = 2;
    localparam int BWC_BIT_TIMER_WK = 6;
    localparam int BWC_BIT_WD_STOP  = 2;
    localparam int BWC_BIT_INT_GLB  = 7;
    localparam int BWC_BIT_MEAS     = 5;
    localparam int BWC_BIT_WAKE_PIN_ENABLE    = 0;
    localparam int BWC_BIT_STAT_ERR = 1;

    // Fail-safe image of the external wake register, bits 7 and 5 kept
    localparam logic [7:0] BWC_FS_EXT_KEEP = 8'ha0;
    localparam logic [7:0] BWC_FS_EXT_SET  = 8'h01;

    // ==========================================================
    // Frame layout: 16 bits, least significant bit first
    // ==========================================================
    localparam logic [4:0] BWC_FRAME_LAST = 5'd15;
    localparam logic [4:0] BWC_DATA_FIRST = 5'd8;

    typedef struct packed {
        logic [7:0] data;
        logic       wr;
        logic [6:0] addr;
    } bwc_frame_type;

    // Low two bits of the transceiver mode field
    typedef enum logic [1:0] {
        BWC_XCVR_OFF     = 2'b00,
        BWC_XCVR_WAKE    = 2'b01,
        BWC_XCVR_RX_ONLY = 2'b10,
        BWC_XCVR_NORMAL  = 2'b11
    } bwc_xcvr_type;

    // Mode-entry events from the device's own mode logic
    typedef struct packed {
        logic sleep_entry;
        logic stop_entry;
        logic stop_to_normal;
        logic failsafe_entry;
        logic soft_reset;
    } bwc_event_type;

endpackage : bwc_pkg

// ---- rtl/bwc_regs.sv ----
`timescale 1ns/10ps
module bwc_regs
    import bwc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       spi_clk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_o,
    input  bwc_event_type   event_i,
    input  wire logic       system_error_flag_i,
    input  wire logic       fail_output_i,
    input  wire logic       dev_mode_i,
    input  wire logic       wake_pin_i,
    input  wire logic       general_pin_i,
    output logic [2:0]      transceiver_mode_o,
    output logic            cyclic_timer_wake_enable_o,
    output logic            watchdog_stop_disable_b1_o,
    output logic            interrupt_global_o,
    output logic            wake_pin_measure_select_o,
    output logic            wake_pin_wake_active_o,
    output logic            general_pin_ctrl_ignore_o,
    output logic [1:0]      general_pin_pull_config_o,
    output logic [1:0]      wake_pin_pull_config_o,
    output logic            wake_pin_level_status_o,
    output logic            general_pin_level_status_o,
    output logic            spi_fail_o
);

    // ==========================================================
    // Link domain: shift in, hold frame, shift out
    // ==========================================================
    logic          spi_arst_n;
    logic [4:0]    bit_cnt_r;
    logic [15:0]   shift_r;
    bwc_frame_type frame_r;
    logic          frame_tog_r;
    logic          miso_r;
    logic [7:0]    rd_byte;
    logic [7:0]    stat_byte;
    logic [6:0]    cur_addr;
    // Select wires of the read path
    logic          hit_bus;
    logic          hit_int;
    logic          hit_ext;
    logic          hit_pull;

    // Snapshot written in the system domain, frozen while select is low
    logic [7:0]    snap_bus_r;
    logic [7:0]    snap_int_r;
    logic [7:0]    snap_ext_r;
    logic [7:0]    snap_pull_r;
    logic          snap_fail_r;

    // Counter and output restart on every deselect
    assign spi_arst_n = rst_n_i & ~spi_cs_n_i;
    assign cur_addr   = shift_r[6:0];

    // Read select from the address bits already shifted in
    assign hit_bus  = (cur_addr == BWC_ADDR_BUS_MODE);
    assign hit_int  = (cur_addr == BWC_ADDR_INT_WAKE);
    assign hit_ext  = (cur_addr == BWC_ADDR_EXT_WAKE);
    assign hit_pull = (cur_addr == BWC_ADDR_PULL);

    // Old register contents go out, never the incoming data
    always_comb begin
        if (hit_bus) begin
            rd_byte = snap_bus_r;
        end else if (hit_int) begin
            rd_byte = snap_int_r;
        end else if (hit_ext) begin
            rd_byte = snap_ext_r;
        end else if (hit_pull) begin
            rd_byte = snap_pull_r;
        end else begin
            rd_byte = BWC_UNMAPPED_READ;
        end
    end
    assign stat_byte = {6'h00, snap_fail_r, 1'b0};

    // Sample on rising edge; counter saturates past one frame
    // Saturation keeps extra clocks from wrapping into a new frame
    always_ff @(posedge spi_clk_i or negedge spi_arst_n) begin
        if (!spi_arst_n) begin
            bit_cnt_r <= 5'd0;
        end else if (bit_cnt_r <= BWC_FRAME_LAST) begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
        end
    end

    always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_r <= 16'h0000;
        end else if (bit_cnt_r <= BWC_FRAME_LAST) begin
            shift_r[bit_cnt_r[3:0]] <= spi_mosi_i;
        end
    end

    // Frame held until the next complete frame; toggle marks it
    always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_r     <= '0;
            frame_tog_r <= 1'b0;
        end else if (bit_cnt_r == BWC_FRAME_LAST) begin
            frame_r     <= {spi_mosi_i, shift_r[14:0]};
            frame_tog_r <= ~frame_tog_r;
        end
    end

    // Change on falling edge so the host samples a settled bit
    always_ff @(negedge spi_clk_i or negedge spi_arst_n) begin
        if (!spi_arst_n) begin
            miso_r <= 1'b0;
        end else if (bit_cnt_r < BWC_DATA_FIRST) begin
            miso_r <= stat_byte[bit_cnt_r[2:0]];
        end else if (bit_cnt_r <= BWC_FRAME_LAST) begin
            miso_r <= rd_byte[bit_cnt_r[2:0]];
        end
    end

    // Enable follows select directly; data idles low while deselected
    assign spi_miso_o    = miso_r;
    assign spi_miso_oe_o = ~spi_cs_n_i;

    // ==========================================================
    // Crossings into the system domain
    // ==========================================================
    logic [2:0] tog_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] wk_sync_r;
    logic [1:0] gp_sync_r;
    logic       frame_done;

    // Two stages for select and pins, three for the toggle; the first stage is never read by logic
    // Toggle crossing: the frame word holds still until the next frame
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_sync_r <= 3'b000;
            cs_sync_r  <= 2'b11;
            wk_sync_r  <= 2'b00;
            gp_sync_r  <= 2'b00;
        end else begin
            tog_sync_r <= {tog_sync_r[1:0], frame_tog_r};
            cs_sync_r  <= {cs_sync_r[0], spi_cs_n_i};
            wk_sync_r  <= {wk_sync_r[0], wake_pin_i};
            gp_sync_r  <= {gp_sync_r[0], general_pin_i};
        end
    end

    assign frame_done = tog_sync_r[2] ^ tog_sync_r[1];

    // ==========================================================
    // Register write decode
    // ==========================================================
    // Stored register images
    logic [7:0] bus_r;
    logic [7:0] int_r;
    logic [7:0] ext_r;
    logic [7:0] pull_r;
    logic       fail_r;
    logic       init_done_r;
    // One-cycle write strobes and their helpers
    logic       wr_bus;
    logic       wr_int;
    logic       wr_ext;
    logic       wr_pull;
    logic       meas_refused;
    logic [7:0] ext_wdata;
    logic       frame_rd;
    logic       frm_hit_bus;
    logic       frm_hit_int;
    logic       frm_hit_ext;
    logic       frm_hit_pull;

    // Frame address decode; frame_r is steady while the strobe is high
    assign frm_hit_bus  = (frame_r.addr == BWC_ADDR_BUS_MODE);
    assign frm_hit_int  = (frame_r.addr == BWC_ADDR_INT_WAKE);
    assign frm_hit_ext  = (frame_r.addr == BWC_ADDR_EXT_WAKE);
    assign frm_hit_pull = (frame_r.addr == BWC_ADDR_PULL);

    // Unmapped addresses raise no strobe, so such writes vanish
    assign wr_bus   = frame_done & frame_r.wr & frm_hit_bus;
    assign wr_int   = frame_done & frame_r.wr & frm_hit_int;
    assign wr_ext   = frame_done & frame_r.wr & frm_hit_ext;
    assign wr_pull  = frame_done & frame_r.wr & frm_hit_pull;
    assign frame_rd = frame_done & ~frame_r.wr;

    // Measurement cannot be switched on under an active fail output
    assign meas_refused = wr_ext & fail_output_i & frame_r.data[BWC_BIT_MEAS];
    assign ext_wdata    = frame_r.data & BWC_MSK_EXT_WAKE
                          & ~(meas_refused ? BWC_FS_EXT_SET << BWC_BIT_MEAS
                                           : 8'h00);

    // ==========================================================
    // Next-state of the transceiver mode register
    // ==========================================================
    logic [7:0]   bus_wr_val;
    logic [7:0]   bus_nxt;
    bwc_xcvr_type low_cur;
    logic         swk_cur;
    logic [7:0]   wake_image;

    assign bus_wr_val = wr_bus ? (frame_r.data & BWC_MSK_BUS_MODE) : bus_r;
    assign low_cur    = bwc_xcvr_type'(bus_wr_val[1:0]);
    assign swk_cur    = bus_wr_val[BWC_BIT_SWK];
    // Only the low bits move; the selective wake bit rides along
    assign wake_image = {5'h00, swk_cur, BWC_XCVR_WAKE};

    // Hardware only ever rewrites the low two bits
    always_comb begin
        bus_nxt = bus_wr_val;
        if (event_i.failsafe_entry) begin
            bus_nxt = wake_image;
        end else if (event_i.sleep_entry) begin
            if (low_cur == BWC_XCVR_NORMAL && !system_error_flag_i) begin
                bus_nxt = wake_image;
            end else if (low_cur == BWC_XCVR_RX_ONLY) begin
                bus_nxt = wake_image;
            end
        end else if (event_i.stop_entry) begin
            bus_nxt = bus_wr_val;
        end
        // Off and wake capable modes keep the field as is
    end

    // ==========================================================
    // Next-state of the wake control registers
    // ==========================================================
    logic [7:0] int_nxt;
    logic [7:0] ext_nxt;
    logic [7:0] pull_nxt;

    // Stop-to-normal clears the disable bit even over a same-cycle write
    always_comb begin
        int_nxt = wr_int ? (frame_r.data & BWC_MSK_INT_WAKE) : int_r;
        if (event_i.stop_to_normal) begin
            int_nxt[BWC_BIT_WD_STOP] = 1'b0;
        end
    end

    // Fail-safe image applies only while the pin is a wake input
    always_comb begin
        ext_nxt = wr_ext ? ext_wdata : ext_r;
        if (event_i.failsafe_entry && !ext_nxt[BWC_BIT_MEAS]) begin
            ext_nxt = (ext_nxt & BWC_FS_EXT_KEEP) | BWC_FS_EXT_SET;
        end
    end

    // Pull fields are host-only; of the mode events only soft reset touches them
    assign pull_nxt = wr_pull ? (frame_r.data & BWC_MSK_PULL) : pull_r;

    // ==========================================================
    // Register storage; defaults reloaded after reset and soft reset
    // ==========================================================
    // Development strap is read only after release, never in reset
    // Soft reset leaves the failure flag alone; a read clears that
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_done_r <= 1'b0;
            bus_r       <= BWC_RST_BUS_MODE;
            int_r       <= BWC_RST_INT_WAKE;
            ext_r       <= BWC_RST_EXT_WAKE;
            pull_r      <= BWC_RST_PULL;
        end else if (!init_done_r || event_i.soft_reset) begin
            init_done_r <= 1'b1;
            bus_r       <= dev_mode_i ? BWC_RST_BUS_DEV : BWC_RST_BUS_MODE;
            int_r       <= BWC_RST_INT_WAKE;
            ext_r       <= BWC_RST_EXT_WAKE;
            pull_r      <= BWC_RST_PULL;
        end else begin
            bus_r       <= bus_nxt;
            int_r       <= int_nxt;
            ext_r       <= ext_nxt;
            pull_r      <= pull_nxt;
        end
    end

    // Failure flag: set by refusal wins over clear by a read frame
    // Limitation: the link shows the flag only in the status byte of a later frame; spi_fail_o has it at once
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fail_r <= 1'b0;
        end else if (meas_refused) begin
            fail_r <= 1'b1;
        end else if (frame_rd) begin
            fail_r <= 1'b0;
        end
    end

    // Snapshot only while deselected, so a frame reads stable data
    // An event landing mid-frame shows in the following read only
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            snap_bus_r  <= BWC_RST_BUS_MODE;
            snap_int_r  <= BWC_RST_INT_WAKE;
            snap_ext_r  <= BWC_RST_EXT_WAKE;
            snap_pull_r <= BWC_RST_PULL;
            snap_fail_r <= 1'b0;
        end else if (cs_sync_r[1]) begin
            snap_bus_r  <= bus_r;
            snap_int_r  <= int_r;
            snap_ext_r  <= ext_r;
            snap_pull_r <= pull_r;
            snap_fail_r <= fail_r;
        end
    end

    // ==========================================================
    // Derived controls and pin level status
    // ==========================================================
    logic meas_sel;
    logic wake_act_r;
    logic gp_ign_r;
    logic wake_pin_level_status_r;
    logic gp_lvl_r;

    assign meas_sel = ext_r[BWC_BIT_MEAS];

    // Registered so downstream sees glitch-free enables
    // Level status trails the pin by three cycles, traded for safe sync
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_act_r <= 1'b0;
            gp_ign_r   <= 1'b0;
            wake_pin_level_status_r   <= 1'b0;
            gp_lvl_r   <= 1'b0;
        end else begin
            wake_act_r <= ext_r[BWC_BIT_WAKE_PIN_ENABLE] & ~meas_sel;
            gp_ign_r   <= meas_sel & ~fail_output_i;
            wake_pin_level_status_r   <= meas_sel ? 1'b0 : wk_sync_r[1];
            gp_lvl_r   <= meas_sel ? 1'b0 : gp_sync_r[1];
        end
    end

    // Register fields straight to the pins, no added latency
    assign transceiver_mode_o         = bus_r[2:0];
    assign cyclic_timer_wake_enable_o = int_r[BWC_BIT_TIMER_WK];
    assign watchdog_stop_disable_b1_o = int_r[BWC_BIT_WD_STOP];
    assign interrupt_global_o         = ext_r[BWC_BIT_INT_GLB];
    assign wake_pin_measure_select_o  = meas_sel;

    // Registered derivations one cycle behind the fields; pull fields and fail flag go straight out
    assign wake_pin_wake_active_o     = wake_act_r;
    assign general_pin_ctrl_ignore_o  = gp_ign_r;
    assign general_pin_pull_config_o  = pull_r[7:6];
    assign wake_pin_pull_config_o     = pull_r[1:0];
    assign wake_pin_level_status_o    = wake_pin_level_status_r;
    assign general_pin_level_status_o = gp_lvl_r;
    assign spi_fail_o                 = fail_r;

endmodule : bwc_regs

// ---- tb/bwc_regs_asserts.sv ----
`timescale 1ns/10ps
module bwc_regs_asserts
    import bwc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  bwc_event_type   event_i,
    input  wire logic       system_error_flag_i,
    input  wire logic       fail_output_i,
    input  wire logic [2:0] transceiver_mode_o,
    input  wire logic       watchdog_stop_disable_b1_o,
    input  wire logic       wake_pin_measure_select_o,
    input  wire logic       wake_pin_wake_active_o,
    input  wire logic       wake_pin_level_status_o,
    input  wire logic       general_pin_level_status_o
);
    // ==========================================================
    // Clocking
    // ==========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // No overriding event in the same cycle
    wire quiet = !event_i.soft_reset && !event_i.failsafe_entry;

    fs_mode_a : assert property (
        event_i.failsafe_entry && !event_i.soft_reset
        |=> transceiver_mode_o == {$past(transceiver_mode_o[2]), 2'b01})
        else $error("fail-safe mode image wrong");
    sleep_norm_a : assert property (
        event_i.sleep_entry && quiet && !system_error_flag_i && transceiver_mode_o[1:0] == 2'b11
        |=> transceiver_mode_o == {$past(transceiver_mode_o[2]), 2'b01})
        else $error("sleep did not leave normal");
    sleep_rx_a : assert property (
        event_i.sleep_entry && quiet && transceiver_mode_o[1:0] == 2'b10
        |=> transceiver_mode_o[1:0] == 2'b01) else $error("sleep kept receive only");
    stop_rx_a : assert property (
        event_i.stop_entry && !event_i.sleep_entry && quiet && transceiver_mode_o[1:0] == 2'b10
        |=> $stable(transceiver_mode_o)) else $error("stop changed receive only");
    low_keep_a : assert property (
        (event_i.sleep_entry || event_i.stop_entry) && quiet && !transceiver_mode_o[1]
        |=> $stable(transceiver_mode_o)) else $error("low mode altered");
    wd_clear_a : assert property (
        event_i.stop_to_normal |=> !watchdog_stop_disable_b1_o)
        else $error("stop disable bit kept");
    meas_refuse_a : assert property (
        $rose(wake_pin_measure_select_o) |-> !$past(fail_output_i))
        else $error("measure set while fail output active");
    level_hold_a : assert property (
        wake_pin_measure_select_o |=> !wake_pin_level_status_o && !general_pin_level_status_o)
        else $error("level status updated in measure");
    wake_gate_a : assert property (
        wake_pin_wake_active_o |-> !$past(wake_pin_measure_select_o))
        else $error("pin wake active in measure");
endmodule : bwc_regs_asserts

bind bwc_regs bwc_regs_asserts u_chk (.clock_i, .rst_n_i, .event_i, .system_error_flag_i,
    .fail_output_i, .transceiver_mode_o, .watchdog_stop_disable_b1_o,
    .wake_pin_measure_select_o, .wake_pin_wake_active_o, .wake_pin_level_status_o,
    .general_pin_level_status_o);

// ---- tb/bwc_regs_tb.sv ----
`timescale 1ns/10ps
module bwc_regs_tb;
    import bwc_pkg::*;
    logic          clock_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          spi_clk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
    bwc_event_type event_i;
    logic          system_error_flag_i, fail_output_i, dev_mode_i;
    logic          wake_pin_i, general_pin_i, spi_fail_o;
    logic [2:0]    transceiver_mode_o;
    logic          cyclic_timer_wake_enable_o, watchdog_stop_disable_b1_o, interrupt_global_o;
    logic          wake_pin_measure_select_o, wake_pin_wake_active_o, general_pin_ctrl_ignore_o;
    logic [1:0]    general_pin_pull_config_o, wake_pin_pull_config_o;
    logic          wake_pin_level_status_o, general_pin_level_status_o;
    logic [7:0]    m [16];
    logic          sf;
    logic [15:0]   rx;
    logic [15:0]   exp_q [$];
    logic [6:0]    addrs [5] = '{7'h04, 7'h06, 7'h07, 7'h08, 7'h05};
    logic [31:0]   seed = 32'h06536874;
    event          got;
    int            err_count = 0;
    int            check_count = 0;
    int            cyc = 0;

    // ==========================================================
    // Clock, pins, watchdog on the run length
    // ==========================================================
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    bwc_regs dut (.*);
    bwc_spi_host host (.spi_clk_o(spi_clk_i), .spi_cs_n_o(spi_cs_n_i),
        .spi_mosi_o(spi_mosi_i), .spi_miso_i(spi_miso_o));

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] msk(input logic [6:0] a);
        return (a == 7'h04) ? 8'h07 : (a == 7'h06) ? 8'h44 : (a == 7'h07) ? 8'ha1 :
               (a == 7'h08) ? 8'hc3 : 8'h00;
    endfunction : msk

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    // Each completed frame is judged against the oldest note
    always @(got) check(rx, exp_q.pop_front());

    // One full frame; the model follows the write afterwards
    task automatic op(input logic [6:0] a, input logic wr, input logic [7:0] d);
        logic [7:0] v;
        v = d & msk(a);
        exp_q.push_back({m[a[3:0]], 6'h00, sf, 1'b0});
        host.xfer({d, wr, a}, 16, int'(rnd() & 32'h7), rx);
        -> got;
        if (wr && a == 7'h07 && v[5] && fail_output_i) begin
            v[5] = 1'b0;
            sf = 1'b1;
        end
        if (wr) m[a[3:0]] = v;
        else sf = 1'b0;
    endtask : op

    // Fresh pin levels each call; four edges cover sync and status flop
    task automatic ports();
        @(negedge clock_i);
        {wake_pin_i, general_pin_i} = 2'(rnd());
        repeat (4) @(negedge clock_i);
        check({4'h0, transceiver_mode_o, cyclic_timer_wake_enable_o, watchdog_stop_disable_b1_o,
               interrupt_global_o, wake_pin_measure_select_o, general_pin_pull_config_o,
               wake_pin_pull_config_o, spi_fail_o}, {4'h0, m[4][2:0], m[6][6], m[6][2], m[7][7],
               m[7][5], m[8][7:6], m[8][1:0], sf});
        check({13'h0, spi_miso_oe_o, wake_pin_wake_active_o, general_pin_ctrl_ignore_o},
              {13'h0, 1'b0, m[7][0] & ~m[7][5], m[7][5] & ~fail_output_i});
        check({14'h0, wake_pin_level_status_o, general_pin_level_status_o},
              {14'h0, wake_pin_i & ~m[7][5], general_pin_i & ~m[7][5]});
    endtask : ports

    // Event pulse 0 sleep, 1 stop, 2 stop-to-normal, 3 fail-safe, 4 soft reset
    task automatic ev(input int k);
        @(negedge clock_i);
        event_i = bwc_event_type'(5'h10 >> k);
        @(negedge clock_i);
        event_i = '0;
        if (k == 0 && (m[4][1:0] == 2'b10 || (m[4][1:0] == 2'b11 && !system_error_flag_i)))
            m[4][1:0] = 2'b01;
        if (k == 2) m[6][2] = 1'b0;
        if (k == 3) begin
            m[4] = {5'h00, m[4][2], 2'b01};
            if (!m[7][5]) m[7] = (m[7] & 8'ha0) | 8'h01;
        end
        if (k == 4) begin
            m[4] = {6'h00, dev_mode_i, dev_mode_i};
            m[6] = 8'h00;
            m[7] = 8'h01;
            m[8] = 8'h00;
        end
        ports();
    endtask : ev

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {system_error_flag_i, fail_output_i, dev_mode_i, wake_pin_i, general_pin_i} = 5'h00;
        event_i = '0;
        m = '{default: 8'h00};
        m[7] = 8'h01;
        sf = 1'b0;
        repeat (20) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        foreach (addrs[i]) op(addrs[i], 1'b0, 8'h00);
        op(7'h05, 1'b1, 8'hff);
        op(7'h05, 1'b0, 8'h00);
        ports();
        $display("test reset_values done");
        for (int i = 0; i < 20; i++) begin
            op(addrs[i % 4], 1'b1, 8'(rnd()));
            ports();
        end
        for (int k = 0; k < 8; k++) begin
            op(7'h04, 1'b1, {5'h1f, 3'(k)});
            op(7'h08, 1'b1, {2'(k), 4'hf, 2'(k)});
            ports();
        end
        host.xfer(16'hff84, 8, 0, rx); // Short frame must be ignored
        op(7'h04, 1'b0, 8'h00);
        $display("test writes done");
        for (int k = 0; k < 12; k++) begin
            system_error_flag_i = (k >= 8);
            op(7'h04, 1'b1, (8'(rnd()) & 8'h04) | 8'(k % 4));
            ev((k / 4) % 2);
        end
        system_error_flag_i = 1'b0;
        op(7'h06, 1'b1, 8'hff);
        ev(2);
        $display("test low_power done");
        op(7'h07, 1'b1, 8'hff);
        op(7'h04, 1'b1, 8'h07);
        ev(3);
        op(7'h07, 1'b1, 8'h80);
        ev(3);
        fail_output_i = 1'b1;
        op(7'h07, 1'b1, 8'h21);
        ports();
        op(7'h07, 1'b0, 8'h00);
        ports();
        fail_output_i = 1'b0;
        $display("test fail_safe done");
        dev_mode_i = 1'b1;
        ev(4);
        op(7'h04, 1'b0, 8'h00);
        dev_mode_i = 1'b0;
        ev(4);
        op(7'h04, 1'b0, 8'h00);
        $display("test soft_reset done");
        conclude();
    end
endmodule : bwc_regs_tb

// ---- tb/bwc_spi_host.sv ----
`timescale 1ns/10ps
module bwc_spi_host (
    output logic      spi_clk_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o,
    input  wire logic spi_miso_i
);
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // Clock stands still between frames; lead slows the first edge
    task automatic xfer(input logic [15:0] frm, input int nbits, input int lead,
                        output logic [15:0] rx);
        rx = '0;
        spi_cs_n_o = 1'b0;
        spi_mosi_o = frm[0];
        #(15 + lead);
        for (int i = 0; i < nbits; i++) begin
            spi_clk_o = 1'b1;
            rx[i] = spi_miso_i;
            #6;
            spi_clk_o = 1'b0;
            spi_mosi_o = (i < 15) ? frm[i+1] : ~frm[15];
            #6;
        end
        spi_mosi_o = ~spi_mosi_o; // No stale bit after the frame
        spi_cs_n_o = 1'b1;
        #40; // Gap covers the register update and cs-high time
    endtask : xfer
endmodule : bwc_spi_host
